// ===== hdl/crc16_byte_generator.sv
`timescale 1ns/1ps
`default_nettype none

module crc16_byte_generator (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Power mode from the system controller
    input wire crc16_pkg::power_mode_t power_mode_i,
    // Options
    input wire logic transpose_i,
    // Byte writes: select high 1 writes the high register, 0 the low one when a seed is pending, else a data byte
    input wire logic wr_valid_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    // Result and status
    output logic [7:0] result_seed_high_o,
    output logic [7:0] result_seed_low_data_o,
    output logic seed_pending_o,
    output logic idle_o
);

    import crc16_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CRC_WIDTH-1:0] crc;
        logic [CRC_WIDTH-1:0] result;
        seq_state_t seq;
    } gen_state_t;

    gen_state_t st_ff;
    gen_state_t nxt_st;

    logic deep_stop;
    logic standby;
    logic q_valid;
    logic q_ready;
    logic [QUEUE_WIDTH-1:0] q_data;
    logic q_is_high;
    logic [7:0] q_byte;
    logic [7:0] data_in;

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    // Wait is not decoded at all, so it runs like run mode
    assign deep_stop = (power_mode_i == PM_DEEP_STOP);
    assign standby = (power_mode_i == PM_STANDBY);

    // ----------------------------------------
    // Write queue
    // ----------------------------------------
    byte_queue #(
        .WIDTH(QUEUE_WIDTH),
        .DEPTH(QUEUE_DEPTH)
    ) u_queue (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .flush_i(deep_stop),
        .in_valid_i(wr_valid_i),
        .in_ready_o(wr_ready_o),
        .in_data_i({wr_high_i, wr_data_i}),
        .out_valid_o(q_valid),
        .out_ready_i(q_ready),
        .out_data_o(q_data)
    );

    // Standby stalls the drain; queued bytes wait for run or wait mode
    assign q_ready = !standby && !deep_stop;
    assign q_is_high = q_data[QUEUE_SEL_POS];
    assign q_byte = q_data[BYTE_WIDTH-1:0];
    assign data_in = transpose_i ? rev_byte(q_byte) : q_byte;

    // ----------------------------------------
    // Seed and shift engine
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        if (deep_stop) begin
            nxt_st.crc = CRC_RESET;
            nxt_st.seq = SEQ_DATA;
        end else if (q_valid && q_ready) begin
            if (q_is_high) begin
                // A high write always restarts seeding
                nxt_st.crc[CRC_WIDTH-1:HIGH_LSB] = q_byte;
                nxt_st.seq = SEQ_SEED_LOW;
            end else begin
                unique case (st_ff.seq)
                    SEQ_SEED_LOW: begin
                        nxt_st.crc[HIGH_LSB-1:0] = q_byte;
                        nxt_st.seq = SEQ_DATA;
                    end
                    SEQ_DATA: begin
                        nxt_st.crc = crc_byte(st_ff.crc, data_in);
                    end
                endcase
            end
        end
        // Presented result tracks the register, optionally reversed
        nxt_st.result = transpose_i ? rev_word(nxt_st.crc) : nxt_st.crc;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff.crc <= CRC_RESET;
            st_ff.result <= CRC_RESET;
            st_ff.seq <= SEQ_DATA;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign result_seed_high_o = st_ff.result[CRC_WIDTH-1:HIGH_LSB];
    assign result_seed_low_data_o = st_ff.result[HIGH_LSB-1:0];
    assign seed_pending_o = (st_ff.seq == SEQ_SEED_LOW);
    assign idle_o = !q_valid;

endmodule

`default_nettype wire

// ===== hdl/crc16_pkg.sv
package crc16_pkg;

    // ----------------------------------------
    // Shift register and polynomial
    // ----------------------------------------
    localparam int CRC_WIDTH = 16;
    localparam int BYTE_WIDTH = 8;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_RESET = 16'h0000;
    localparam int HIGH_LSB = 8;

    // ----------------------------------------
    // Write queue layout
    // ----------------------------------------
    localparam int QUEUE_DEPTH = 32;
    localparam int QUEUE_WIDTH = 9;
    localparam int QUEUE_SEL_POS = 8;

    // ----------------------------------------
    // Power modes, Gray along run-wait-stop3-stop12
    // ----------------------------------------
    typedef enum logic [1:0] {
        PM_RUN = 2'h0,
        PM_WAIT = 2'h1,
        PM_STANDBY = 2'h3,
        PM_DEEP_STOP = 2'h2
    } power_mode_t;

    // ----------------------------------------
    // Seed sequencing
    // ----------------------------------------
    typedef enum logic [0:0] {
        SEQ_DATA = 1'h0,
        SEQ_SEED_LOW = 1'h1
    } seq_state_t;

    // ----------------------------------------
    // Shared arithmetic
    // ----------------------------------------
    function automatic logic [7:0] rev_byte(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        return r;
    endfunction

    function automatic logic [15:0] rev_word(input logic [15:0] w);
        return {rev_byte(w[7:0]), rev_byte(w[15:8])};
    endfunction

    // One byte, MSB first, no augmentation, no final inversion
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        logic fb;
        c = crc;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            fb = c[15] ^ d[i];
            c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return c;
    endfunction

endpackage

// ===== hdl/byte_queue.sv
`timescale 1ns/1ps
`default_nettype none

module byte_queue #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } queue_state_t;

    queue_state_t st_ff;
    queue_state_t nxt_st;
    logic do_wr;
    logic do_rd;

    assign in_ready_o = (st_ff.count != (PW + 1)'(DEPTH));
    assign out_valid_o = (st_ff.count != '0);
    assign out_data_o = st_ff.mem[st_ff.rd_ptr];
    assign do_wr = in_valid_i && in_ready_o;
    assign do_rd = out_valid_o && out_ready_i;

    always_comb begin
        nxt_st = st_ff;
        if (flush_i) begin
            nxt_st.wr_ptr = '0;
            nxt_st.rd_ptr = '0;
            nxt_st.count = '0;
        end else begin
            if (do_wr) begin
                nxt_st.mem[st_ff.wr_ptr] = in_data_i;
                nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
            end
            if (do_rd) begin
                nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                nxt_st.count = st_ff.count + 1'b1;
            end else if (do_rd && !do_wr) begin
                nxt_st.count = st_ff.count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule

`default_nettype wire

// ===== bench/crc16_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module crc16_cpu_model (
    input wire logic clk_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic high_o,
    output logic [7:0] data_o
);
    initial begin
        valid_o = 1'b0;
        high_o = 1'b0;
        data_o = 8'hA5;
    end
    // Called on a rising edge; holds the byte until taken
    task automatic put(input logic h, input logic [7:0] d);
        logic r;
        valid_o <= 1'b1;
        high_o <= h;
        data_o <= d;
        // Ready is judged before the edge, not after the queue updates
        do begin
            @(negedge clk_i);
            r = (ready_i === 1'b1);
            @(posedge clk_i);
        end while (!r);
    endtask
    // Released lines stop showing the last byte
    task automatic drop();
        valid_o <= 1'b0;
        high_o <= ~high_o;
        data_o <= ~data_o;
    endtask
endmodule
`default_nettype wire

// ===== bench/crc16_byte_generator_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module crc16_checker (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire crc16_pkg::power_mode_t power_mode_i,
    input wire logic transpose_i,
    input wire logic wr_valid_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_ready_o,
    input wire logic [7:0] result_seed_high_o,
    input wire logic [7:0] result_seed_low_data_o,
    input wire logic seed_pending_o,
    input wire logic idle_o
);
    import crc16_pkg::*;
    wire logic [15:0] res = {result_seed_high_o, result_seed_low_data_o};
    wire logic [15:0] rev = {<<{res}};
    wire logic act = !transpose_i && power_mode_i inside {PM_RUN, PM_WAIT};
    wire logic sby = power_mode_i == PM_STANDBY;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_take(h);
        wr_valid_i && wr_ready_o && wr_high_i == h && idle_o && act ##1 act;
    endsequence
    sequence s_hold;
        sby && $stable(transpose_i) ##1 sby && $stable(transpose_i);
    endsequence
    sequence s_flip;
        sby && $stable(transpose_i) ##1 sby && $changed(transpose_i) ##1 sby && $stable(transpose_i);
    endsequence
    property p_hi;
        s_take(1'b1) |=> seed_pending_o && result_seed_high_o == $past(wr_data_i, 2);
    endproperty
    a_hi: assert property (p_hi) else $error("high seed");
    property p_lo;
        seed_pending_o ##0 s_take(1'b0) |=> !seed_pending_o && res[7:0] == $past(wr_data_i, 2);
    endproperty
    a_lo: assert property (p_lo) else $error("low seed");
    property p_deep;
        power_mode_i == PM_DEEP_STOP |=> res == 16'h0000 && !seed_pending_o;
    endproperty
    a_deep: assert property (p_deep) else $error("deep state");
    property p_flush;
        power_mode_i == PM_DEEP_STOP && !wr_valid_i |=> idle_o;
    endproperty
    a_flush: assert property (p_flush) else $error("deep queue");
    property p_hold;
        s_hold |-> $stable(res) && $stable(seed_pending_o);
    endproperty
    a_hold: assert property (p_hold) else $error("standby moved");
    property p_busy;
        sby && !idle_o |=> !idle_o;
    endproperty
    a_busy: assert property (p_busy) else $error("standby drained");
    property p_flip;
        s_flip |-> rev == $past(res, 2);
    endproperty
    a_flip: assert property (p_flip) else $error("transpose");
    property p_room;
        idle_o |-> wr_ready_o;
    endproperty
    a_room: assert property (p_room) else $error("ready");
endmodule
bind crc16_byte_generator crc16_checker chk (.*);
`default_nettype wire

// ===== bench/crc16_byte_generator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin err_count++; $display("Error %s expected %h seen %h", n, e, s); end end
module crc16_byte_generator_tb_top;
    import crc16_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    power_mode_t power_mode_i = PM_RUN;
    logic transpose_i = 1'b0;
    logic wr_valid_i, wr_high_i, wr_ready_o, seed_pending_o, idle_o;
    logic [7:0] wr_data_i, result_seed_high_o, result_seed_low_data_o;
    wire logic [15:0] res = {result_seed_high_o, result_seed_low_data_o};
    logic [15:0] rnd = 16'h8C96;
    int err_count = 0, check_count = 0, mcrc = 0, mpend = 0, m0;
    always #50 clk_i = ~clk_i;
    crc16_byte_generator uut (.*);
    crc16_cpu_model cpu (.clk_i, .ready_i(wr_ready_o), .valid_o(wr_valid_i), .high_o(wr_high_i),
        .data_o(wr_data_i));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic int step(input int c, input int d);
        for (int i = 7; i >= 0; i--) begin
            c = ((c << 1) & 32'hFFFF) ^ ((((c >> 15) ^ (d >> i)) & 1) ? 32'h1021 : 32'h0);
        end
        return c;
    endfunction
    task automatic wr(input logic h, input logic [7:0] d);
        logic [7:0] v;
        cpu.put(h, d);
        v = d;
        if (transpose_i) v = {<<{d}};
        if (h) begin
            mcrc = (mcrc & 32'hFF) | (int'(d) << 8);
            mpend = 1;
        end else if (mpend != 0) begin
            mcrc = (mcrc & 32'hFF00) | int'(d);
            mpend = 0;
        end else begin
            mcrc = step(mcrc, int'(v));
        end
    endtask
    task automatic chk_res(input string n);
        logic [15:0] e;
        cpu.drop();
        repeat (2) @(posedge clk_i);
        for (int k = 0; k < 40 && idle_o !== 1'b1; k++) @(posedge clk_i);
        @(posedge clk_i);
        #1;
        e = mcrc[15:0];
        if (transpose_i) e = {<<{e}};
        `CHK(n, e, res)
        `CHK("pending", mpend[0], seed_pending_o)
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #(3000 * 100);
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        `CHK("reset", 19'h00003, {res, seed_pending_o, idle_o, wr_ready_o})
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int s = 0; s < 3; s++) begin
            power_mode_i <= (s == 1) ? PM_WAIT : PM_RUN;
            transpose_i <= (s == 2);
            wr(1'b1, rnd[15:8]);
            chk_res("high");
            wr(1'b0, rnd[7:0]);
            chk_res("seed");
            repeat (9) begin
                rnd = lfsr(rnd);
                wr(1'b0, rnd[7:0]);
            end
            chk_res("crc");
        end
        power_mode_i <= PM_STANDBY;
        @(posedge clk_i);
        transpose_i <= 1'b0;
        chk_res("flip");
        m0 = mcrc;
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            rnd = lfsr(rnd);
            wr(1'b0, rnd[7:0]);
        end
        cpu.drop();
        #1;
        `CHK("full", 2'b00, {wr_ready_o, idle_o})
        `CHK("held", m0[15:0], res)
        @(posedge clk_i);
        power_mode_i <= PM_RUN;
        chk_res("resume");
        wr(1'b1, 8'h5A);
        cpu.drop();
        power_mode_i <= PM_DEEP_STOP;
        repeat (3) @(posedge clk_i);
        power_mode_i <= PM_RUN;
        mcrc = 0;
        mpend = 0;
        chk_res("deep");
        wr(1'b0, 8'h31);
        chk_res("after");
        tally_and_finish();
    end
endmodule
`default_nettype wire
